// ---- rtl/tlhc_cfg.svh ----
// timing and field constants for the decoder pin controller
`ifndef TLHC_CFG_SVH
`define TLHC_CFG_SVH
`define TLHC_SEL_W 3
`define TLHC_OUT_N 8
`define TLHC_CLK_PERIOD_NS 20
// longest output delay after an input change, in ns
`define TLHC_TPD_NS 26
`define TLHC_SETTLE_CYC ((`TLHC_TPD_NS + `TLHC_CLK_PERIOD_NS - 1) / `TLHC_CLK_PERIOD_NS)
`define TLHC_SETTLE_W 4
`endif

// ---- rtl/tlhc_ctrl.sv ----
// controller driving a 3-to-8 line decoder through its pins
`timescale 1ns/100ps
`default_nettype none
`include "tlhc_cfg.svh"
module tlhc_ctrl (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // user request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [`TLHC_SEL_W-1:0] REQ_SEL,
  input wire logic REQ_DATA,
  input wire logic REQ_DEMUX,
  // result
  output logic RSP_VALID,
  output logic [`TLHC_OUT_N-1:0] RSP_LINES,
  output logic RSP_OK,
  // decoder pins
  output logic SELECT_BIT_0,
  output logic SELECT_BIT_1,
  output logic SELECT_BIT_2,
  output logic ENABLE_HIGH_TRUE,
  output logic ENABLE_LOW_TRUE_A_N,
  output logic ENABLE_LOW_TRUE_B_N,
  input wire logic [`TLHC_OUT_N-1:0] DECODED_OUT
);
  import tlhc_pkg::*;
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [`TLHC_OUT_N-1:0] lines_sync;
  genvar gi;
  generate
    for (gi = 0; gi < `TLHC_OUT_N; gi++) begin : g_sync
      tlhc_sync u_sync (
        .clk(REF_CLK),
        .rst(SRST),
        .pin_in(DECODED_OUT[gi]),
        .sync_out(lines_sync[gi])
      );
    end
  endgenerate
  // ****************************************
  // sequencer
  // ****************************************
  tlhc_state_t state_ff, nxt_state;
  logic [`TLHC_SEL_W-1:0] sel_ff, nxt_sel;
  logic en_ff, nxt_en;
  logic [`TLHC_SETTLE_W-1:0] cnt_ff, nxt_cnt;
  logic [`TLHC_OUT_N-1:0] lines_ff, nxt_lines;
  logic ok_ff, nxt_ok;
  logic valid_ff, nxt_valid;
  logic [`TLHC_OUT_N-1:0] expect_lines;
  // settle spans tpd plus the two synchroniser stages
  localparam logic [`TLHC_SETTLE_W-1:0] SETTLE_CNT = `TLHC_SETTLE_W'(`TLHC_SETTLE_CYC + 2);
  // taking edge to response edge: drive, settle count, sample, register
  localparam int RSP_LAT = int'(SETTLE_CNT) + 3;

  // expected decode: only the indexed line low while enabled, all lines high otherwise
  always_comb begin
    expect_lines = '1;
    if (en_ff) begin
      expect_lines[sel_ff] = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_en = en_ff;
    nxt_cnt = cnt_ff;
    nxt_lines = lines_ff;
    nxt_ok = ok_ff;
    nxt_valid = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (REQ_VALID) begin
          nxt_sel = REQ_SEL;
          // demux mode gates enable with data
          nxt_en = REQ_DEMUX ? REQ_DATA : 1'b1;
          nxt_state = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        nxt_cnt = SETTLE_CNT;
        nxt_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        nxt_cnt = cnt_ff - `TLHC_SETTLE_W'(1);
        if (cnt_ff == `TLHC_SETTLE_W'(1)) begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        nxt_lines = lines_sync;
        // exactly one line per code while enabled
        nxt_ok = (lines_sync == expect_lines);
        nxt_valid = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_ff <= ST_IDLE;
      sel_ff <= '0;
      en_ff <= 1'b0;
      cnt_ff <= '0;
      lines_ff <= '1;
      ok_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      en_ff <= nxt_en;
      cnt_ff <= nxt_cnt;
      lines_ff <= nxt_lines;
      ok_ff <= nxt_ok;
      valid_ff <= nxt_valid;
    end
  end
  // ****************************************
  // cascade bank qualification
  // ****************************************
  // single decoder: the upper address bits always equal this bank's index
  localparam logic [1:0] BANK_IDX = 2'h0;
  logic [1:0] upper_bits;
  logic bank_hi;
  logic bank_lo_a_n;
  logic bank_lo_b_n;
  assign upper_bits = BANK_IDX;
  always_comb begin
    bank_hi = 1'b1;
    bank_lo_a_n = 1'b0;
    bank_lo_b_n = 1'b0;
    case (BANK_IDX)
      2'h0: begin
        bank_lo_a_n = upper_bits[0];
        bank_lo_b_n = upper_bits[1];
      end
      2'h1: begin
        bank_hi = upper_bits[0];
        bank_lo_a_n = upper_bits[1];
      end
      2'h2: begin
        bank_hi = upper_bits[1];
        bank_lo_a_n = upper_bits[0];
      end
      default: begin
        // the one inverter a 32-line cascade needs
        bank_hi = upper_bits[0];
        bank_lo_a_n = ~upper_bits[1];
      end
    endcase
  end
  // ****************************************
  // pin and result drive
  // ****************************************
  // pins always at a valid level from reset
  assign SELECT_BIT_0 = sel_ff[0];
  assign SELECT_BIT_1 = sel_ff[1];
  assign SELECT_BIT_2 = sel_ff[2];
  // only the high-true enable carries data, low-true ones qualify the bank
  assign ENABLE_HIGH_TRUE = en_ff & bank_hi;
  assign ENABLE_LOW_TRUE_A_N = bank_lo_a_n;
  assign ENABLE_LOW_TRUE_B_N = bank_lo_b_n;
  assign REQ_READY = (state_ff == ST_IDLE);
  assign RSP_VALID = valid_ff;
  assign RSP_LINES = lines_ff;
  assign RSP_OK = ok_ff;
  // ****************************************
  // checks
  // ****************************************
  // pins held mid-request
  pins_stable_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_ff != ST_IDLE && $past(state_ff) != ST_IDLE) |-> $stable({sel_ff, en_ff}))
    else $error("decoder pins moved during a request");
  resp_timing_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY) |-> ##RSP_LAT RSP_VALID)
    else $error("response not at the fixed settle time");
  disabled_high_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_ff == ST_SAMPLE && !en_ff) |=> (RSP_OK == (RSP_LINES == 8'hFF)))
    else $error("disabled check does not expect all lines high");
  ok_onehot_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (RSP_VALID && RSP_OK && en_ff) |-> (RSP_LINES == ~(8'h01 << sel_ff)))
    else $error("accepted lines are not the indexed one low");
  demux_enable_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY && REQ_DEMUX) |=> (ENABLE_HIGH_TRUE == $past(REQ_DATA)))
    else $error("demux data not on enable");
  decode_enable_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY && !REQ_DEMUX) |=> ENABLE_HIGH_TRUE)
    else $error("plain decode left the decoder disabled");
  sel_capture_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY) |=> ({SELECT_BIT_2, SELECT_BIT_1, SELECT_BIT_0} == $past(REQ_SEL)))
    else $error("select pins do not follow request");
  // own bank keeps low-true enables on
  bank_enable_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    !ENABLE_LOW_TRUE_A_N && !ENABLE_LOW_TRUE_B_N)
    else $error("low-true enables not asserted for the own bank");
  ready_low_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY) |=> !REQ_READY [*3])
    else $error("ready returned too early");
  valid_pulse_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    RSP_VALID |=> !RSP_VALID)
    else $error("response valid longer than one cycle");
  // result holds until the next response
  result_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    !RSP_VALID |-> $stable({RSP_LINES, RSP_OK}))
    else $error("result changed without a response");
  cov_ok_c: cover property (@(posedge REF_CLK) disable iff (SRST) RSP_VALID && RSP_OK && en_ff);
  cov_off_c: cover property (@(posedge REF_CLK) disable iff (SRST) RSP_VALID && !en_ff);
  cov_bad_c: cover property (@(posedge REF_CLK) disable iff (SRST) RSP_VALID && !RSP_OK);
  cov_b2b_c: cover property (@(posedge REF_CLK) disable iff (SRST) RSP_VALID && REQ_VALID && REQ_READY);
endmodule
`default_nettype wire

// ---- rtl/tlhc_pkg.sv ----
// types for the decoder pin controller
package tlhc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_SETTLE, ST_SAMPLE} tlhc_state_t;
endpackage

// ---- rtl/tlhc_sync.sv ----
// two-flop synchroniser for one pin input
`timescale 1ns/100ps
`default_nettype none
module tlhc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and synchronised level
  input wire logic pin_in,
  output logic sync_out
);
  logic meta_ff;
  logic sync_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ---- tb/tlhc_ctrl_test.sv ----
// self-checking bench for the decoder pin controller
`timescale 1ns/100ps
`default_nettype none
`include "tlhc_cfg.svh"
module tlhc_ctrl_test;
  logic ref_clk, srst, req_valid, req_ready, req_data, req_demux;
  logic [2:0] req_sel;
  logic rsp_valid, rsp_ok, s0, s1, s2, en_hi, en_a_n, en_b_n;
  logic [7:0] rsp_lines, dec, flip;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int failures, check_count, cyc;
  tlhc_ctrl dut (.REF_CLK(ref_clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_SEL(req_sel), .REQ_DATA(req_data), .REQ_DEMUX(req_demux), .RSP_VALID(rsp_valid),
    .RSP_LINES(rsp_lines), .RSP_OK(rsp_ok), .SELECT_BIT_0(s0), .SELECT_BIT_1(s1),
    .SELECT_BIT_2(s2), .ENABLE_HIGH_TRUE(en_hi), .ENABLE_LOW_TRUE_A_N(en_a_n),
    .ENABLE_LOW_TRUE_B_N(en_b_n), .DECODED_OUT(dec));
  tlhc_dec_model model (.sel_0(s0), .sel_1(s1), .sel_2(s2), .en_hi(en_hi),
    .en_lo_a_n(en_a_n), .en_lo_b_n(en_b_n), .flip_mask(flip), .dec_out(dec));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // notes the expected decode, then holds the request until taken
  // a nonzero mask makes the far-side decoder faulty for this request
  task automatic send(input logic [2:0] sel, input logic data, input logic demux, input logic [7:0] mask);
    logic on;
    logic [7:0] lines;
    on = demux ? data : 1'b1;
    lines = on ? ~(8'h01 << sel) : 8'hFF;
    exp_q.push_back({lines ^ mask, mask == 8'h00});
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_sel = sel;
    req_data = data;
    req_demux = demux;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    @(negedge ref_clk);
    req_valid = 1'b0;
    // fault only after the earlier response is sampled
    flip = mask;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test;
    end else if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected rsp", 9'h000, 9'h1FF);
      else begin
        e = exp_q.pop_front();
        chk("rsp_lines_ok", e, {rsp_lines, rsp_ok});
        chk("low_enables", 9'h000, {7'h00, en_a_n, en_b_n});
      end
    end
  end
  initial begin
    {srst, req_valid, req_sel, req_data, req_demux} = 7'h40;
    flip = 8'h00;
    failures = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(73));
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    chk("reset_rsp", 9'h1FE, {rsp_lines, rsp_ok});
    for (int i = 0; i < 8; i++) send(3'(i), 1'b0, 1'b0, 8'h00);
    $display("test sweep done");
    for (int i = 0; i < 16; i++) send(3'(i), i[3], 1'b1, 8'h00);
    $display("test demux done");
    repeat (12) send(3'($urandom), 1'($urandom), 1'($urandom), 8'h00);
    $display("test random done");
    repeat (4) send(3'($urandom), 1'($urandom), 1'($urandom), 8'($urandom) | 8'h01);
    for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge ref_clk);
    chk("queue_left", 9'h000, 9'(exp_q.size()));
    $display("test fault done");
    end_of_test;
  end
endmodule
`default_nettype wire

// ---- tb/tlhc_dec_model.sv ----
// behavioural 3-to-8 decoder on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
`include "tlhc_cfg.svh"
module tlhc_dec_model #(
  parameter int DLY_NS = `TLHC_TPD_NS
) (
  // select pins
  input wire logic sel_0,
  input wire logic sel_1,
  input wire logic sel_2,
  // enable pins
  input wire logic en_hi,
  input wire logic en_lo_a_n,
  input wire logic en_lo_b_n,
  // injected line faults, zero for a healthy decoder
  input wire logic [`TLHC_OUT_N-1:0] flip_mask,
  // decoded lines
  output logic [`TLHC_OUT_N-1:0] dec_out
);
  logic en;
  logic [2:0] sel;
  assign en = en_hi && !en_lo_a_n && !en_lo_b_n;
  assign sel = {sel_2, sel_1, sel_0};
  // worst-case delay so the controller gets no slack
  // one line low while enabled, all high otherwise
  assign #(DLY_NS) dec_out = (en ? ~(8'h01 << sel) : 8'hFF) ^ flip_mask;
endmodule
`default_nettype wire
